// [rtl/audio_output_gain_pll_divider_ctrl.sv]
// Control register bank for the audio outputs, input gains and PLL dividers.
// Assumes the control serial port is decoded upstream into a one-cycle write
// strobe with address and data, and a read address answered one cycle later.
`timescale 1ns/1ns

// Functional notes
// R1: Speaker and earpiece outputs are on when their enable bit is 1 and off when 0.
// R2: A disabled headphone channel is off without the capless option and muted with it.
// R3: All outputs are forced off while the top mixer-code bit is 0.
// R4: Mono gain code maps -12,-9,-6,-3,0,3,6,9 dB for codes 0 to 7.
// R5: Each analog gain code maps -6 dB at 0 rising 3 dB per step to 15 dB.
// R6: Each DAC gain code maps -3, 0, 3, 6 dB for codes 0 to 3.
// R7: Input divider code 0 is off, otherwise divides by (code+1)/2 up to 64.
// R8: Software keeps the comparison frequency between 0.5 MHz and 5 MHz.
// R9: Feedback code 0 is off, codes 1 to 10 divide by 10, higher codes by the code.
// R10: Software keeps comparison frequency times N under 55 MHz, or 80 MHz on high range.
// R11: Output divider code 0 is off, otherwise divides by (code+1)/2 up to 8.
// R12: Software picks the output divider for the standard audio or USB clocks.
// R13: Effective feedback ratio is integer code plus fraction/32; Fout = Fin*N/(M*P).
// R14: Every control register resets to zero, so outputs and dividers start off.
module audio_output_gain_pll_divider_ctrl (
  input  wire logic                     I_CLOCK,
  input  wire logic                     I_RST,
  input  wire audio_ctrl_pkg::wr_req_t  I_WR_REQ,
  input  wire logic [7:0]               I_RD_ADDR,
  output logic [7:0]                    O_RD_DATA,
  output audio_ctrl_pkg::out_state_t    O_OUT_STATE,
  output logic signed [7:0]             O_MONO_GAIN_DB,
  output logic signed [7:0]             O_ANA_LEFT_GAIN_DB,
  output logic signed [7:0]             O_ANA_RIGHT_GAIN_DB,
  output logic signed [7:0]             O_DAC_LEFT_GAIN_DB,
  output logic signed [7:0]             O_DAC_RIGHT_GAIN_DB,
  output logic                          O_PLL_IN_EN,
  output logic [7:0]                    O_PLL_IN_RATIO_X2,
  output logic                          O_PLL_FB_EN,
  output logic [12:0]                   O_PLL_FB_RATIO_X32,
  output logic [1:0]                    O_PLL_DITHER_LEVEL,
  output logic                          O_HIGH_RANGE_OSC_SEL,
  output logic                          O_PLL_OUT_EN,
  output logic [4:0]                    O_PLL_OUT_RATIO_X2
);
  import audio_ctrl_pkg::*;

  // ***************************************************************
  // Register storage
  // ***************************************************************
  logic [7:0] mixer_mode;
  logic [7:0] output_enable_control;
  logic [7:0] analog_left_right_input_gain;
  logic [7:0] mono_and_dac_input_gain;
  logic [7:0] pll_input_divider;
  logic [7:0] pll_feedback_divider;
  logic [7:0] pll_feedback_fraction;
  logic [7:0] pll_output_divider;
  logic [7:0] next_rd_data;

  function automatic logic hit(input wr_req_t req, input logic [7:0] addr);
    return req.en && (req.addr == addr);
  endfunction : hit

  // Each register clears on reset and keeps only its implemented bits. [R14]
  always_ff @(posedge I_CLOCK) begin
    if (I_RST) mixer_mode <= REG_RESET;
    else if (hit(I_WR_REQ, ADDR_MIXER)) mixer_mode <= I_WR_REQ.data & MASK_MIXER;
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_RST) output_enable_control <= REG_RESET;
    else if (hit(I_WR_REQ, ADDR_OUT_CTRL)) begin
      output_enable_control <= I_WR_REQ.data & MASK_OUT_CTRL;
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_RST) analog_left_right_input_gain <= REG_RESET;
    else if (hit(I_WR_REQ, ADDR_ANA_GAIN)) begin
      analog_left_right_input_gain <= I_WR_REQ.data & MASK_ANA_GAIN;
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_RST) mono_and_dac_input_gain <= REG_RESET;
    else if (hit(I_WR_REQ, ADDR_MONO_DAC)) begin
      mono_and_dac_input_gain <= I_WR_REQ.data & MASK_MONO_DAC;
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_RST) pll_input_divider <= REG_RESET;
    else if (hit(I_WR_REQ, ADDR_IN_DIV)) pll_input_divider <= I_WR_REQ.data & MASK_IN_DIV;
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_RST) pll_feedback_divider <= REG_RESET;
    else if (hit(I_WR_REQ, ADDR_FB_DIV)) pll_feedback_divider <= I_WR_REQ.data & MASK_FB_DIV;
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_RST) pll_feedback_fraction <= REG_RESET;
    else if (hit(I_WR_REQ, ADDR_PLL_FRAC)) begin
      pll_feedback_fraction <= I_WR_REQ.data & MASK_PLL_FRAC;
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_RST) pll_output_divider <= REG_RESET;
    else if (hit(I_WR_REQ, ADDR_OUT_DIV)) pll_output_divider <= I_WR_REQ.data & MASK_OUT_DIV;
  end

  // ***************************************************************
  // Read-back
  // ***************************************************************
  // Unmapped addresses read as zero rather than stale data.
  always_comb begin
    case (I_RD_ADDR)
      ADDR_MIXER:    next_rd_data = mixer_mode;
      ADDR_OUT_CTRL: next_rd_data = output_enable_control;
      ADDR_ANA_GAIN: next_rd_data = analog_left_right_input_gain;
      ADDR_MONO_DAC: next_rd_data = mono_and_dac_input_gain;
      ADDR_IN_DIV:   next_rd_data = pll_input_divider;
      ADDR_FB_DIV:   next_rd_data = pll_feedback_divider;
      ADDR_PLL_FRAC: next_rd_data = pll_feedback_fraction;
      ADDR_OUT_DIV:  next_rd_data = pll_output_divider;
      default:       next_rd_data = 8'h00;
    endcase
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_RST) O_RD_DATA <= REG_RESET;
    else O_RD_DATA <= next_rd_data;
  end

  // ***************************************************************
  // Output enables
  // ***************************************************************
  logic mixer_code_top_bit;
  logic speaker_out_en;
  logic earpiece_out_en;
  logic headphone_left_out_en;
  logic headphone_right_out_en;
  logic capless_headphone_sel;

  assign mixer_code_top_bit     = mixer_mode[BIT_MIX_TOP];
  assign speaker_out_en         = output_enable_control[BIT_SPEAKER];
  assign earpiece_out_en        = output_enable_control[BIT_EARPIECE];
  assign headphone_left_out_en  = output_enable_control[BIT_HP_LEFT];
  assign headphone_right_out_en = output_enable_control[BIT_HP_RIGHT];
  assign capless_headphone_sel  = output_enable_control[BIT_CAPLESS];

  // The global gate wins over everything, including the capless mute. [R3]
  function automatic hp_state_t hp_decode(input logic gate, input logic en,
                                          input logic capless);
    if (!gate) return HP_OFF;
    else if (en) return HP_ON;
    else if (capless) return HP_MUTE; // [R2]
    else return HP_OFF;
  endfunction : hp_decode

  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      O_OUT_STATE <= '{speaker_on: 1'b0, earpiece_on: 1'b0, hp_left: HP_OFF, hp_right: HP_OFF};
    end else begin
      O_OUT_STATE.speaker_on  <= mixer_code_top_bit && speaker_out_en;  // [R1] [R3]
      O_OUT_STATE.earpiece_on <= mixer_code_top_bit && earpiece_out_en; // [R1] [R3]
      O_OUT_STATE.hp_left     <= hp_decode(mixer_code_top_bit, headphone_left_out_en,
                                           capless_headphone_sel);
      O_OUT_STATE.hp_right    <= hp_decode(mixer_code_top_bit, headphone_right_out_en,
                                           capless_headphone_sel);
    end
  end

  // ***************************************************************
  // Input gains
  // ***************************************************************
  // Mono code 2 decodes on the linear ladder (-6 dB) as the neighbours imply. [R4]
  gain_step_decode #(.CODE_W(MONO_W), .BASE_DB(MONO_BASE_DB)) u_mono_gain (
    .i_clock   (I_CLOCK),
    .i_rst     (I_RST),
    .i_code    (mono_and_dac_input_gain[MONO_LSB +: MONO_W]),
    .o_gain_db (O_MONO_GAIN_DB)
  );

  gain_step_decode #(.CODE_W(ANA_W), .BASE_DB(ANA_BASE_DB)) u_ana_left_gain ( // [R5]
    .i_clock   (I_CLOCK),
    .i_rst     (I_RST),
    .i_code    (analog_left_right_input_gain[ANA_L_LSB +: ANA_W]),
    .o_gain_db (O_ANA_LEFT_GAIN_DB)
  );

  gain_step_decode #(.CODE_W(ANA_W), .BASE_DB(ANA_BASE_DB)) u_ana_right_gain ( // [R5]
    .i_clock   (I_CLOCK),
    .i_rst     (I_RST),
    .i_code    (analog_left_right_input_gain[ANA_R_LSB +: ANA_W]),
    .o_gain_db (O_ANA_RIGHT_GAIN_DB)
  );

  gain_step_decode #(.CODE_W(DAC_W), .BASE_DB(DAC_BASE_DB)) u_dac_left_gain ( // [R6]
    .i_clock   (I_CLOCK),
    .i_rst     (I_RST),
    .i_code    (mono_and_dac_input_gain[DAC_L_LSB +: DAC_W]),
    .o_gain_db (O_DAC_LEFT_GAIN_DB)
  );

  gain_step_decode #(.CODE_W(DAC_W), .BASE_DB(DAC_BASE_DB)) u_dac_right_gain ( // [R6]
    .i_clock   (I_CLOCK),
    .i_rst     (I_RST),
    .i_code    (mono_and_dac_input_gain[DAC_R_LSB +: DAC_W]),
    .o_gain_db (O_DAC_RIGHT_GAIN_DB)
  );

  // ***************************************************************
  // PLL dividers
  // ***************************************************************
  half_step_divider_decode #(.CODE_W(M_W)) u_input_div ( // [R7]
    .i_clock    (I_CLOCK),
    .i_rst      (I_RST),
    .i_code     (pll_input_divider[M_W-1:0]),
    .o_enable   (O_PLL_IN_EN),
    .o_ratio_x2 (O_PLL_IN_RATIO_X2)
  );

  half_step_divider_decode #(.CODE_W(P_W)) u_output_div ( // [R11]
    .i_clock    (I_CLOCK),
    .i_rst      (I_RST),
    .i_code     (pll_output_divider[P_W-1:0]),
    .o_enable   (O_PLL_OUT_EN),
    .o_ratio_x2 (O_PLL_OUT_RATIO_X2)
  );

  logic [N_W-1:0] feedback_int;
  logic [FRAC_W-1:0] feedback_fraction_code;

  assign feedback_fraction_code = pll_feedback_fraction[FRAC_LSB +: FRAC_W];

  // Small codes are clamped to the least ratio the loop can run at. [R9]
  always_comb begin
    if (pll_feedback_divider == N_OFF_CODE) feedback_int = '0;
    else if (pll_feedback_divider <= N_FLOOR_RATIO) feedback_int = N_FLOOR_RATIO;
    else feedback_int = pll_feedback_divider;
  end

  // Ratio in 1/32 units: integer part above the 5-bit fraction. [R13]
  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      O_PLL_FB_EN        <= 1'b0;
      O_PLL_FB_RATIO_X32 <= '0;
    end else begin
      O_PLL_FB_EN        <= (pll_feedback_divider != N_OFF_CODE); // [R9]
      O_PLL_FB_RATIO_X32 <= (pll_feedback_divider == N_OFF_CODE) ? 13'h0000
                            : {feedback_int, feedback_fraction_code};
    end
  end

  // The oscillator range only moves the software limit on comparison frequency times N. [R10]
  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      O_PLL_DITHER_LEVEL   <= '0;
      O_HIGH_RANGE_OSC_SEL <= 1'b0;
    end else begin
      O_PLL_DITHER_LEVEL   <= pll_feedback_fraction[DITHER_LSB +: DITHER_W];
      O_HIGH_RANGE_OSC_SEL <= pll_feedback_fraction[BIT_HIGH_OSC];
    end
  end

  // ***************************************************************
  // Assertions
  // ***************************************************************
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (I_RST);

  sequence s_gate_closed;
    !mixer_code_top_bit;
  endsequence

  sequence s_mono_write;
    hit(I_WR_REQ, ADDR_MONO_DAC);
  endsequence

  AST_SPEAKER_FOLLOWS: assert property ( // [R1]
    O_OUT_STATE.speaker_on == ($past(speaker_out_en) && $past(mixer_code_top_bit)))
    else $error("speaker state does not follow its enable");
  AST_HP_CAPLESS_MUTE: assert property ( // [R2]
    (mixer_code_top_bit && !headphone_left_out_en && capless_headphone_sel)
      |=> O_OUT_STATE.hp_left == HP_MUTE)
    else $error("disabled capless headphone not muted");
  AST_HP_PLAIN_OFF: assert property ( // [R2]
    (mixer_code_top_bit && !headphone_right_out_en && !capless_headphone_sel)
      |=> O_OUT_STATE.hp_right == HP_OFF)
    else $error("disabled headphone not off");
  AST_GATE_ALL_OFF: assert property ( // [R3]
    s_gate_closed |=> (O_OUT_STATE == out_state_t'{1'b0, 1'b0, HP_OFF, HP_OFF}))
    else $error("output on while mixer gate closed");
  AST_MONO_GAIN: assert property ( // [R4]
    s_mono_write ##1 !hit(I_WR_REQ, ADDR_MONO_DAC)
      |=> O_MONO_GAIN_DB == 8'(MONO_BASE_DB
          + int'($past(I_WR_REQ.data[MONO_LSB +: MONO_W], 2)) * GAIN_STEP_DB))
    else $error("mono gain decode wrong two cycles after write");
  AST_ANA_TOP: assert property ( // [R5]
    (analog_left_right_input_gain[ANA_L_LSB +: ANA_W] == 3'h7) |=> O_ANA_LEFT_GAIN_DB == 8'sd15)
    else $error("analog gain top code not 15 dB");
  AST_DAC_RANGE: assert property ( // [R6]
    O_DAC_RIGHT_GAIN_DB == 8'(DAC_BASE_DB
      + int'($past(mono_and_dac_input_gain[DAC_R_LSB +: DAC_W])) * GAIN_STEP_DB))
    else $error("dac right gain does not follow its code");
  AST_M_RATIO: assert property ( // [R7]
    (pll_input_divider != REG_RESET) |=> O_PLL_IN_EN
      && O_PLL_IN_RATIO_X2 == $past(pll_input_divider) + 8'h01)
    else $error("input divider ratio wrong");
  AST_N_FLOOR: assert property ( // [R9]
    (pll_feedback_divider != N_OFF_CODE && pll_feedback_divider <= N_FLOOR_RATIO)
      |=> O_PLL_FB_RATIO_X32[12:FRAC_W] == N_FLOOR_RATIO)
    else $error("feedback divider not clamped to 10");
  AST_P_OFF: assert property ( // [R11]
    (pll_output_divider == REG_RESET) |=> !O_PLL_OUT_EN && O_PLL_OUT_RATIO_X2 == 5'h00)
    else $error("output divider not off at code 0");
  AST_N_FRACTION: assert property ( // [R13]
    O_PLL_FB_EN |-> O_PLL_FB_RATIO_X32[FRAC_W-1:0] == $past(feedback_fraction_code))
    else $error("fraction not carried into feedback ratio");
  AST_RESET_CLEAR: assert property (@(posedge I_CLOCK) disable iff (1'b0) // [R14]
    $past(I_RST) |-> {mixer_mode, output_enable_control, analog_left_right_input_gain,
                      mono_and_dac_input_gain, pll_input_divider, pll_feedback_divider,
                      pll_feedback_fraction, pll_output_divider} == '0)
    else $error("register not cleared by reset");

endmodule : audio_output_gain_pll_divider_ctrl

// [rtl/audio_ctrl_pkg.sv]
// Package: register map, field layout, gain coding and carrier types for the
// audio output, gain and clock-divider control bank.
// Assumes a single 100 MHz control clock and a decoded register write/read port.
package audio_ctrl_pkg;

  // ***************************************************************
  // Bus widths and clock
  // ***************************************************************
  localparam int          ADDR_W         = 8;
  localparam int          DATA_W         = 8;
  localparam int          CLOCK_MHZ      = 100;

  // ***************************************************************
  // Register offsets
  // ***************************************************************
  localparam logic [7:0]  ADDR_MIXER     = 8'h00;
  localparam logic [7:0]  ADDR_OUT_CTRL  = 8'h01;
  localparam logic [7:0]  ADDR_ANA_GAIN  = 8'h07;
  localparam logic [7:0]  ADDR_MONO_DAC  = 8'h08;
  localparam logic [7:0]  ADDR_IN_DIV    = 8'h0a;
  localparam logic [7:0]  ADDR_FB_DIV    = 8'h0b;
  localparam logic [7:0]  ADDR_PLL_FRAC  = 8'h0c;
  localparam logic [7:0]  ADDR_OUT_DIV   = 8'h0d;

  // ***************************************************************
  // Implemented-bit masks and reset value
  // ***************************************************************
  localparam logic [7:0]  MASK_MIXER     = 8'h0f;
  localparam logic [7:0]  MASK_OUT_CTRL  = 8'h1f;
  localparam logic [7:0]  MASK_ANA_GAIN  = 8'h3f;
  localparam logic [7:0]  MASK_MONO_DAC  = 8'h7f;
  localparam logic [7:0]  MASK_IN_DIV    = 8'h7f;
  localparam logic [7:0]  MASK_FB_DIV    = 8'hff;
  localparam logic [7:0]  MASK_PLL_FRAC  = 8'hff;
  localparam logic [7:0]  MASK_OUT_DIV   = 8'h0f;
  localparam logic [7:0]  REG_RESET      = 8'h00;

  // ***************************************************************
  // Field positions and widths
  // ***************************************************************
  localparam int          BIT_SPEAKER    = 0;
  localparam int          BIT_HP_LEFT    = 1;
  localparam int          BIT_HP_RIGHT   = 2;
  localparam int          BIT_EARPIECE   = 3;
  localparam int          BIT_CAPLESS    = 4;
  localparam int          BIT_MIX_TOP    = 3;
  localparam int          BIT_HIGH_OSC   = 7;
  localparam int          ANA_L_LSB      = 0;
  localparam int          ANA_R_LSB      = 3;
  localparam int          MONO_LSB       = 0;
  localparam int          DAC_L_LSB      = 3;
  localparam int          DAC_R_LSB      = 5;
  localparam int          FRAC_LSB       = 0;
  localparam int          DITHER_LSB     = 5;
  localparam int          ANA_W          = 3;
  localparam int          MONO_W         = 3;
  localparam int          DAC_W          = 2;
  localparam int          DITHER_W       = 2;
  localparam int          M_W            = 7;
  localparam int          N_W            = 8;
  localparam int          P_W            = 4;
  localparam int          FRAC_W         = 5;

  // ***************************************************************
  // Gain coding (dB) and feedback divider limits
  // ***************************************************************
  localparam int          MONO_BASE_DB   = -12;
  localparam int          ANA_BASE_DB    = -6;
  localparam int          DAC_BASE_DB    = -3;
  localparam int          GAIN_STEP_DB   = 3;
  localparam logic [7:0]  N_FLOOR_RATIO  = 8'h0a;
  localparam logic [7:0]  N_OFF_CODE     = 8'h00;

  // ***************************************************************
  // Carrier types
  // ***************************************************************
  typedef struct packed {
    logic                 en;
    logic [ADDR_W-1:0]    addr;
    logic [DATA_W-1:0]    data;
  } wr_req_t;

  typedef enum logic [1:0] {
    HP_OFF  = 2'b00,
    HP_ON   = 2'b01,
    HP_MUTE = 2'b10
  } hp_state_t;

  typedef struct packed {
    logic                 speaker_on;
    logic                 earpiece_on;
    hp_state_t            hp_left;
    hp_state_t            hp_right;
  } out_state_t;

endpackage : audio_ctrl_pkg

// [rtl/gain_step_decode.sv]
// Linear gain-code decoder: registered dB value = base + code * step.
// Assumes synchronous active-high reset; reset shows the code-zero gain.
`timescale 1ns/1ns
module gain_step_decode #(
  parameter int CODE_W  = 3,
  parameter int BASE_DB = -6
) (
  input  wire logic              i_clock,
  input  wire logic              i_rst,
  input  wire logic [CODE_W-1:0] i_code,
  output logic signed [7:0]      o_gain_db
);
  import audio_ctrl_pkg::*;

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_gain_db <= 8'(BASE_DB);
    end else begin
      o_gain_db <= 8'(BASE_DB + int'(i_code) * GAIN_STEP_DB);
    end
  end

endmodule : gain_step_decode

// [rtl/half_step_divider_decode.sv]
// Half-step divider decoder: code 0 disables, otherwise ratio = (code+1)/2.
// The ratio is carried doubled so that half steps stay exact integers.
`timescale 1ns/1ns
module half_step_divider_decode #(
  parameter int CODE_W = 7
) (
  input  wire logic              i_clock,
  input  wire logic              i_rst,
  input  wire logic [CODE_W-1:0] i_code,
  output logic                   o_enable,
  output logic [CODE_W:0]        o_ratio_x2
);
  import audio_ctrl_pkg::*;

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_enable   <= 1'b0;
      o_ratio_x2 <= '0;
    end else if (i_code == '0) begin
      o_enable   <= 1'b0;
      o_ratio_x2 <= '0;
    end else begin
      o_enable   <= 1'b1;
      o_ratio_x2 <= (CODE_W+1)'(i_code) + (CODE_W+1)'(1);
    end
  end

endmodule : half_step_divider_decode

// [dv/host_port_model.sv]
// Host model for the control port: issues register writes and reads.
// Assumes the bench keeps the clock running and releases reset first.
`timescale 1ns/1ns
module host_port_model (
  input  wire logic                     i_clock,
  output audio_ctrl_pkg::wr_req_t       o_wr_req,
  output logic [7:0]                    o_rd_addr,
  input  wire logic [7:0]               i_rd_data
);
  import audio_ctrl_pkg::*;

  initial begin
    o_wr_req  = '0;
    o_rd_addr = 8'h00;
  end

  // A released write bus shows the inverse of its last value, so a stale
  // address or data byte can never pass for a fresh request.
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    @(posedge i_clock);
    #1 o_wr_req = '{en: 1'b1, addr: addr, data: data};
    @(posedge i_clock);
    #1 o_wr_req = '{en: 1'b0, addr: ~addr, data: ~data};
  endtask : write_reg

  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
    @(posedge i_clock);
    #1 o_rd_addr = addr;
    @(posedge i_clock);
    #1 data = i_rd_data;
  endtask : read_reg
endmodule : host_port_model

// [dv/audio_output_gain_pll_divider_ctrl_tb.sv]
// Testbench: drives the register port through the host model and checks
// every decoded output against values worked out here.
`timescale 1ns/1ns
module audio_output_gain_pll_divider_ctrl_tb;
  import audio_ctrl_pkg::*;
  logic              clock;
  logic              rst;
  wr_req_t           wr_req;
  logic [7:0]        rd_addr;
  logic [7:0]        rd_data;
  out_state_t        out_state;
  logic signed [7:0] mono_db, ana_l_db, ana_r_db, dac_l_db, dac_r_db;
  logic              m_en, n_en, p_en, osc;
  logic [7:0]        m_x2;
  logic [12:0]       n_x32;
  logic [4:0]        p_x2;
  logic [1:0]        dither;
  logic [7:0]        rv;
  int                bad_count = 0;
  int                n_checks = 0;
  logic [7:0]        mixv[2] = '{8'h07, 8'h08};
  logic [7:0]        regs[9] = '{8'h00, 8'h01, 8'h07, 8'h08, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h04};
  logic [7:0]        mc[5] = '{8'h00, 8'h01, 8'h02, 8'h07, 8'h7e};
  logic [7:0]        nc[6] = '{8'h00, 8'h01, 8'h0a, 8'h0b, 8'h13, 8'hf9};
  logic [7:0]        pc[5] = '{8'h00, 8'h01, 8'h09, 8'h0e, 8'h0f};
  logic [7:0]        r;
  logic [15:0]       e;

  host_port_model host (.i_clock(clock), .o_wr_req(wr_req), .o_rd_addr(rd_addr),
                        .i_rd_data(rd_data));

  audio_output_gain_pll_divider_ctrl dut (
    .I_CLOCK(clock), .I_RST(rst), .I_WR_REQ(wr_req), .I_RD_ADDR(rd_addr),
    .O_RD_DATA(rd_data), .O_OUT_STATE(out_state), .O_MONO_GAIN_DB(mono_db),
    .O_ANA_LEFT_GAIN_DB(ana_l_db), .O_ANA_RIGHT_GAIN_DB(ana_r_db),
    .O_DAC_LEFT_GAIN_DB(dac_l_db), .O_DAC_RIGHT_GAIN_DB(dac_r_db),
    .O_PLL_IN_EN(m_en), .O_PLL_IN_RATIO_X2(m_x2), .O_PLL_FB_EN(n_en),
    .O_PLL_FB_RATIO_X32(n_x32), .O_PLL_DITHER_LEVEL(dither),
    .O_HIGH_RANGE_OSC_SEL(osc), .O_PLL_OUT_EN(p_en), .O_PLL_OUT_RATIO_X2(p_x2));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic chk_db(input string name, input logic [7:0] seen, input int exp);
    check(name, {8'h00, seen}, {8'h00, 8'(exp)});
  endtask : chk_db

  // Decoded outputs trail the register by one more edge.
  task automatic settle();
    repeat (2) @(posedge clock);
    #1;
  endtask : settle

  function automatic logic [5:0] exp_out(input logic [7:0] mix, input logic [7:0] ctl);
    logic       g;
    logic [1:0] off;
    g   = mix[BIT_MIX_TOP];
    off = ctl[BIT_CAPLESS] ? HP_MUTE : HP_OFF;
    return {g & ctl[BIT_SPEAKER], g & ctl[BIT_EARPIECE],
            g ? (ctl[BIT_HP_LEFT] ? HP_ON : off) : HP_OFF,
            g ? (ctl[BIT_HP_RIGHT] ? HP_ON : off) : HP_OFF};
  endfunction : exp_out

  task automatic report_and_stop();
    if (bad_count == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    #200000;
    bad_count++;
    report_and_stop();
  end

  initial begin
    rst = 1'b1;
    repeat (8) @(posedge clock);
    #1 rst = 1'b0;
    foreach (regs[i]) begin
      host.read_reg(regs[i], rv);
      check("reset_reg", {8'h00, rv}, 16'h0000);
    end
    check("reset_out", 16'(out_state), 16'h0000);
    check("reset_div", {13'h0, m_en, n_en, p_en}, 16'h0000);
    chk_db("reset_mono", mono_db, MONO_BASE_DB);
    foreach (mixv[i]) begin
      host.write_reg(ADDR_MIXER, mixv[i]);
      for (int c = 0; c < 32; c++) begin
        host.write_reg(ADDR_OUT_CTRL, 8'(c));
        settle();
        check("out_state", 16'(out_state), 16'(exp_out(mixv[i], 8'(c))));
      end
    end
    for (int c = 0; c < 8; c++) begin
      host.write_reg(ADDR_ANA_GAIN, {2'b00, 3'(7 - c), 3'(c)});
      host.write_reg(ADDR_MONO_DAC, {1'b0, 2'(c), ~2'(c), 3'(c)});
      settle();
      chk_db("mono_db", mono_db, -12 + 3 * c);
      chk_db("ana_l_db", ana_l_db, -6 + 3 * c);
      chk_db("ana_r_db", ana_r_db, -6 + 3 * (7 - c));
      chk_db("dac_l_db", dac_l_db, -3 + 3 * (3 - c % 4));
      chk_db("dac_r_db", dac_r_db, -3 + 3 * (c % 4));
    end
    host.write_reg(8'h04, 8'h5a);
    host.read_reg(8'h04, rv);
    check("unmapped", {8'h00, rv}, 16'h0000);
    // Fraction 17 with the fast oscillator set, so a 60 MHz VCO stays legal.
    host.write_reg(ADDR_PLL_FRAC, 8'hd1);
    foreach (mc[i]) begin
      host.write_reg(ADDR_IN_DIV, mc[i]);
      settle();
      e = {7'h0, mc[i] != 0, mc[i] == 0 ? 8'h00 : mc[i] + 8'h01};
      check("m_div", {7'h0, m_en, m_x2}, e);
    end
    foreach (nc[i]) begin
      host.write_reg(ADDR_FB_DIV, nc[i]);
      settle();
      r = nc[i] == 0 ? 8'h00 : (nc[i] <= 8'h0a ? 8'h0a : nc[i]);
      e = {2'h0, nc[i] != 0, nc[i] == 0 ? 13'h0 : {r, 5'h11}};
      check("n_div", {2'h0, n_en, n_x32}, e);
    end
    check("osc_dither", {13'h0, osc, dither}, 16'h0006);
    foreach (pc[i]) begin
      host.write_reg(ADDR_OUT_DIV, pc[i] | 8'hf0);
      settle();
      e = {10'h0, pc[i] != 0, pc[i] == 0 ? 5'h00 : 5'(pc[i] + 1)};
      check("p_div", {10'h0, p_en, p_x2}, e);
    end
    host.read_reg(ADDR_OUT_DIV, rv);
    check("p_readback", {8'h00, rv}, 16'h000f);
    report_and_stop();
  end
endmodule : audio_output_gain_pll_divider_ctrl_tb
